/* logic/cfgmem_shifter.sv */
// Serial engine for the four-wire configuration memory port
`timescale 1ns/1ps
module cfgmem_shifter
  import strap_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic start,
  input wire logic hold,
  input wire logic [4:0] last_bit,
  input wire logic [31:0] tx_word,
  input wire logic serial_in,
  output logic busy,
  output logic [31:0] rx_word,
  output logic serial_clock,
  output logic serial_out,
  output logic select_n
);

  typedef struct packed {
    shift_state_e state;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic sdo;
    logic [5:0] left;
    logic [31:0] tx;
    logic [31:0] rx;
  } shifter_s;

  localparam shifter_s SHIFTER_RESET = '{
    state: SH_IDLE, div: 8'h00, sclk: 1'b0, cs_n: 1'b1, sdo: 1'b0,
    left: 6'h00, tx: 32'h0000_0000, rx: 32'h0000_0000};

  shifter_s r;
  shifter_s n;
  logic tick;

  always_comb begin
    n = r;
    tick = (r.div == SCLK_DIV_LAST);
    if (clear) begin
      n = SHIFTER_RESET;
    end else begin
      unique case (r.state)
        SH_IDLE: begin
          n.div = 8'h00;
          n.sclk = 1'b0;
          // Select stays low between transfers while hold is set
          n.cs_n = ~hold; // see (R08)
          if (start) begin
            n.state = SH_SHIFT;
            n.cs_n = 1'b0; // see (R08)
            n.sdo = tx_word[31]; // see (R10)
            n.tx = {tx_word[30:0], 1'b0};
            n.left = {1'b0, last_bit} + 6'h01;
          end
        end
        SH_SHIFT: begin
          n.div = tick ? 8'h00 : r.div + 8'h01;
          if (tick) begin
            if (!r.sclk) begin
              n.sclk = 1'b1; // see (R09)
              n.rx = {r.rx[30:0], serial_in}; // see (R11)
              n.left = r.left - 6'h01;
            end else begin
              n.sclk = 1'b0;
              if (r.left == 6'h00) begin
                n.state = SH_TAIL;
              end else begin
                n.sdo = r.tx[31]; // see (R10)
                n.tx = {r.tx[30:0], 1'b0};
              end
            end
          end
        end
        SH_TAIL: begin
          n.div = tick ? 8'h00 : r.div + 8'h01;
          if (tick) begin
            n.state = SH_IDLE;
            n.sdo = 1'b0;
            n.cs_n = ~hold;
          end
        end
        default: begin
          n = SHIFTER_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= SHIFTER_RESET;
    end else begin
      r <= n;
    end
  end

  assign busy = (r.state != SH_IDLE);
  assign rx_word = r.rx;
  assign serial_clock = r.sclk;
  assign serial_out = r.sdo;
  assign select_n = r.cs_n;

endmodule // cfgmem_shifter

/* logic/strap_cfg_pkg.sv */
// Constants and types shared by the strap, clock-request and config port
package strap_cfg_pkg;

  // ***********************************************************
  // Clocking and serial memory timing
  // ***********************************************************
  localparam int unsigned CLK_MHZ = 200;
  // Least half period of the serial memory clock, in ns
  localparam int unsigned SCLK_HALF_NS = 50;
  localparam int unsigned SCLK_HALF_CYC_RAW =
    (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_CYC_RAW < 1) ? 1 : SCLK_HALF_CYC_RAW;
  localparam logic [7:0] SCLK_DIV_LAST = 8'(SCLK_HALF_CYC - 1);

  // ***********************************************************
  // Register byte addresses
  // ***********************************************************
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_MEM_CTRL = 8'h04;
  localparam logic [7:0] ADDR_MEM_TX = 8'h08;
  localparam logic [7:0] ADDR_MEM_RX = 8'h0C;
  localparam logic [7:0] ADDR_MGMT = 8'h10;
  localparam logic [7:0] ADDR_REFCLK_OFF = 8'h98;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int STRAP_UP_LSB = 0;
  localparam int STRAP_RSVD_BIT = 2;
  localparam int STRAP_PL512_BIT = 3;
  localparam int STRAP_MPS_LSB = 4;
  localparam int STRAP_MEM_EN_BIT = 7;
  localparam int STRAP_CAPT_BIT = 8;
  localparam int STRAP_REQ_LSB = 12;
  localparam int STRAP_REFEN_LSB = 16;
  localparam int CTL_LEN_LSB = 0;
  localparam int CTL_START_BIT = 8;
  localparam int CTL_HOLD_BIT = 9;
  localparam int CTL_BUSY_BIT = 16;
  localparam int MGMT_SCL_LOW_BIT = 0;
  localparam int MGMT_SDA_LOW_BIT = 1;
  localparam int MGMT_SCL_IN_BIT = 2;
  localparam int MGMT_SDA_IN_BIT = 3;
  localparam int MGMT_SCLK_IN_BIT = 4;

  // ***********************************************************
  // Codes and reset values
  // ***********************************************************
  localparam int REFCLK_COUNT = 3;
  localparam logic [2:0] REFCLK_OFF_RESET = 3'h0;
  localparam logic [1:0] UPSEL_PORT0 = 2'h0;
  localparam logic [1:0] UPSEL_PORT1 = 2'h1;
  localparam logic [1:0] UPSEL_RSVD = 2'h2;
  localparam logic [1:0] UPSEL_PORT2 = 2'h3;
  localparam logic [1:0] PORT_NUM_0 = 2'h0;
  localparam logic [1:0] PORT_NUM_1 = 2'h1;
  localparam logic [1:0] PORT_NUM_2 = 2'h2;
  localparam logic [2:0] MPS_CODE_256 = 3'h1;
  localparam logic [2:0] MPS_CODE_512 = 3'h2;
  localparam logic [4:0] CTL_LEN_RESET = 5'h07;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SHIFT = 2'b01,
    SH_TAIL = 2'b10
  } shift_state_e;

endpackage

/* logic/switch_strap_and_eeprom_port.sv */
// Strap capture, reference clock gating, config memory and management pins
//
// Overview of operation
// (R01) Each reference clock output runs while its request input is low.
// (R02) Software register at offset 98h disables reference clock outputs.
// (R03) Upstream strap 11 selects port 2; code 10 is reserved.
// (R04) Upstream strap 01 selects port 1.
// (R05) Upstream strap 00, the pulled-down default, selects port 0.
// (R06) Payload strap high advertises 512 byte payload, else 256 byte.
// (R07) Select pin sampled at initialization: low bypasses the memory.
// (R08) After initialization the select pin is driven low for an access.
// (R09) Device drives the serial clock of the memory port.
// (R10) Command, address and data shift out on the serial output pin.
// (R11) Memory returns read data, captured on the serial input pin.
// (R12) Management data line is open-drain, driven low or released.
// (R13) Management clock is only pulled low or released, never driven high.
// (R14) System reset returns all internal state, straps included, to reset.
// (R15) Shared strap pins become debug outputs only after capture.
// (R16) Straps are latched once at system reset release and then held.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module switch_strap_and_eeprom_port
  import strap_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic system_reset_n,
  input wire logic [strap_cfg_pkg::REFCLK_COUNT-1:0] refclk_request_n,
  output logic [strap_cfg_pkg::REFCLK_COUNT-1:0] refclk_enable,
  input wire logic [1:0] upstream_port_strap,
  input wire logic large_payload_strap,
  output logic [1:0] upstream_port,
  output logic [2:0] max_payload_code,
  output logic cfgmem_enabled,
  input wire logic cfgmem_serial_clock_in,
  output logic cfgmem_serial_clock_out,
  output logic cfgmem_serial_clock_oe,
  output logic cfgmem_serial_out,
  input wire logic cfgmem_serial_in,
  input wire logic cfgmem_select_n_in,
  output logic cfgmem_select_n_out,
  output logic cfgmem_select_n_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [4:0] debug_out,
  output logic debug_out_oe
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic captured;
    logic [1:0] up_port;
    logic strap_rsvd;
    logic pl512;
    logic mem_en;
    logic [REFCLK_COUNT-1:0] refclk_off;
    logic [REFCLK_COUNT-1:0] refclk_en;
    logic [4:0] ctl_len;
    logic ctl_hold;
    logic start;
    logic [31:0] tx;
    logic scl_low;
    logic sda_low;
    logic od_level;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic readyout;
    logic [4:0] dbg;
    logic [2:0] mps;
    logic mem_oe;
  } top_s;

  localparam top_s TOP_RESET = '{
    captured: 1'b0, up_port: PORT_NUM_0, strap_rsvd: 1'b0,
    pl512: 1'b0, mem_en: 1'b0, refclk_off: REFCLK_OFF_RESET,
    refclk_en: '0, ctl_len: CTL_LEN_RESET, ctl_hold: 1'b0,
    start: 1'b0, tx: 32'h0000_0000, scl_low: 1'b0, sda_low: 1'b0,
    od_level: 1'b0, dphase: 1'b0, dwrite: 1'b0, daddr: 8'h00,
    rdata: 32'h0000_0000, readyout: 1'b1, dbg: 5'h00,
    mps: MPS_CODE_256, mem_oe: 1'b0};

  top_s r;
  top_s n;
  logic sh_busy;
  logic [31:0] sh_rx;
  logic sh_clear;

  // ***********************************************************
  // Decoding helpers
  // ***********************************************************
  // Strap code to upstream port number; the reserved code falls
  // back to port 0 and is flagged in the status register.
  function automatic logic [1:0] port_of(input logic [1:0] code);
    logic [1:0] port;
    port = PORT_NUM_0;
    unique case (code)
      UPSEL_PORT0: port = PORT_NUM_0; // see (R05)
      UPSEL_PORT1: port = PORT_NUM_1; // see (R04)
      UPSEL_PORT2: port = PORT_NUM_2; // see (R03)
      UPSEL_RSVD: port = PORT_NUM_0; // see (R03)
    endcase
    return port;
  endfunction

  function automatic logic [31:0] read_word(input top_s s,
                                            input logic busy,
                                            input logic [31:0] rx);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (s.daddr)
      ADDR_STRAP: begin
        w[STRAP_UP_LSB +: 2] = s.up_port;
        w[STRAP_RSVD_BIT] = s.strap_rsvd;
        w[STRAP_PL512_BIT] = s.pl512;
        w[STRAP_MPS_LSB +: 3] = s.pl512 ? MPS_CODE_512 : MPS_CODE_256;
        w[STRAP_MEM_EN_BIT] = s.mem_en;
        w[STRAP_CAPT_BIT] = s.captured;
        w[STRAP_REQ_LSB +: REFCLK_COUNT] = refclk_request_n;
        w[STRAP_REFEN_LSB +: REFCLK_COUNT] = s.refclk_en;
      end
      ADDR_MEM_CTRL: begin
        w[CTL_LEN_LSB +: 5] = s.ctl_len;
        w[CTL_HOLD_BIT] = s.ctl_hold;
        w[CTL_BUSY_BIT] = busy | s.start;
      end
      ADDR_MEM_TX: w = s.tx;
      ADDR_MEM_RX: w = rx;
      ADDR_MGMT: begin
        w[MGMT_SCL_LOW_BIT] = s.scl_low;
        w[MGMT_SDA_LOW_BIT] = s.sda_low;
        w[MGMT_SCL_IN_BIT] = scl_in;
        w[MGMT_SDA_IN_BIT] = sda_in;
        w[MGMT_SCLK_IN_BIT] = cfgmem_serial_clock_in;
      end
      ADDR_REFCLK_OFF: w[REFCLK_COUNT-1:0] = s.refclk_off;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    n = r;
    n.start = 1'b0;
    if (!system_reset_n) begin
      // Bus stays answerable; everything else returns to reset
      n = TOP_RESET; // see (R14)
    end else begin
      // Straps are sampled on the first cycle out of reset only,
      // while the shared pins are still inputs.
      if (!r.captured) begin
        n.captured = 1'b1; // see (R16)
        n.up_port = port_of(upstream_port_strap);
        n.strap_rsvd = (upstream_port_strap == UPSEL_RSVD); // see (R03)
        n.pl512 = large_payload_strap; // see (R06)
        n.mem_en = cfgmem_select_n_in; // see (R07)
      end

      // Request low and no software disable enables the output
      n.refclk_en = ~refclk_request_n & ~r.refclk_off; // see (R01) (R02)

      n.dbg = {sh_busy, r.up_port, r.mem_en, r.pl512};
      n.mps = n.pl512 ? MPS_CODE_512 : MPS_CODE_256; // see (R06)
      // Pin enables come from a flop so the shared pins never glitch
      n.mem_oe = n.captured & n.mem_en; // see (R08) (R09)

      // Bus address phase
      if (hsel && hready && htrans[1]) begin
        n.dphase = 1'b1;
        n.dwrite = hwrite;
        n.daddr = haddr[7:0];
        // Reads take one wait state so the word reflects any write
        // completing in this same cycle.
        n.readyout = hwrite;
      end else if (r.readyout) begin
        n.dphase = 1'b0;
      end

      // Read data phase, wait state ends here
      if (r.dphase && !r.dwrite && !r.readyout) begin
        n.rdata = read_word(r, sh_busy, sh_rx);
        n.readyout = 1'b1;
      end

      // Write data phase, zero wait
      if (r.dphase && r.dwrite && r.readyout) begin
        unique case (r.daddr)
          ADDR_MEM_CTRL: begin
            n.ctl_len = hwdata[CTL_LEN_LSB +: 5];
            n.ctl_hold = hwdata[CTL_HOLD_BIT];
            // A start while busy or in bypass is dropped
            n.start = hwdata[CTL_START_BIT] && !sh_busy && !r.start
                      && r.mem_en && r.captured; // see (R07)
          end
          ADDR_MEM_TX: n.tx = hwdata;
          ADDR_MGMT: begin
            n.scl_low = hwdata[MGMT_SCL_LOW_BIT]; // see (R13)
            n.sda_low = hwdata[MGMT_SDA_LOW_BIT]; // see (R12)
          end
          ADDR_REFCLK_OFF: begin
            n.refclk_off = hwdata[REFCLK_COUNT-1:0]; // see (R02)
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= TOP_RESET;
    end else begin
      r <= n;
    end
  end

  // ***********************************************************
  // Configuration memory engine
  // ***********************************************************
  assign sh_clear = !system_reset_n; // see (R14)

  cfgmem_shifter u_shifter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(sh_clear),
    .start(r.start),
    .hold(r.ctl_hold),
    .last_bit(r.ctl_len),
    .tx_word(r.tx),
    .serial_in(cfgmem_serial_in),
    .busy(sh_busy),
    .rx_word(sh_rx),
    .serial_clock(cfgmem_serial_clock_out),
    .serial_out(cfgmem_serial_out),
    .select_n(cfgmem_select_n_out)
  );

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign hrdata = r.rdata;
  assign hreadyout = r.readyout;
  assign hresp = r.od_level;
  assign refclk_enable = r.refclk_en;
  assign upstream_port = r.up_port;
  assign max_payload_code = r.mps;
  assign cfgmem_enabled = r.mem_en;
  // The select pin is a strap until capture; in bypass it is
  // never driven so the board strap keeps its level.
  assign cfgmem_serial_clock_oe = r.mem_oe; // see (R09)
  assign cfgmem_select_n_oe = r.mem_oe; // see (R08)
  // Open-drain: level held low, only the enable moves
  assign scl_out = r.od_level; // see (R13)
  assign scl_oe = r.scl_low; // see (R13)
  assign sda_out = r.od_level; // see (R12)
  assign sda_oe = r.sda_low; // see (R12)
  assign debug_out = r.dbg;
  assign debug_out_oe = r.captured; // see (R15)

endmodule // switch_strap_and_eeprom_port

/* testbench/cfgmem_partner.sv */
// Behavioural serial configuration memory seen from the device pins
`timescale 1ns/1ps
module cfgmem_partner (
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [31:0] reply,
  output logic sdo,
  output logic [31:0] got
);
  logic [31:0] sh;
  initial begin
    sdo = 1'b0;
    got = 32'h0;
    sh = 32'h0;
  end
  always @(negedge select_n) begin
    sh = reply;
    got = 32'h0;
    sdo = reply[31];
  end
  always @(posedge sclk) begin
    if (!select_n)
      got = {got[30:0], sdi};
  end
  always @(negedge sclk) begin
    if (!select_n) begin
      sh = {sh[30:0], 1'b0};
      sdo = sh[31];
    end
  end
  // No pull on this line: a released output must not look valid
  always @(posedge select_n) sdo = ~sdo;
endmodule // cfgmem_partner

/* testbench/switch_strap_and_eeprom_port_assertions.sv */
// Concurrent checks on strap capture, clock gating and memory pins
`timescale 1ns/1ps
module strap_port_checker
  import strap_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic system_reset_n,
  input wire logic [REFCLK_COUNT-1:0] refclk_request_n,
  input wire logic [REFCLK_COUNT-1:0] refclk_enable,
  input wire logic [1:0] upstream_port_strap,
  input wire logic large_payload_strap,
  input wire logic [1:0] upstream_port,
  input wire logic [2:0] max_payload_code,
  input wire logic cfgmem_enabled,
  input wire logic cfgmem_serial_clock_out,
  input wire logic cfgmem_serial_clock_oe,
  input wire logic cfgmem_serial_out,
  input wire logic cfgmem_select_n_out,
  input wire logic cfgmem_select_n_oe,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic debug_out_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [1:0] exp_port;
  always_comb begin
    case (upstream_port_strap)
      UPSEL_PORT1: exp_port = PORT_NUM_1;
      UPSEL_PORT2: exp_port = PORT_NUM_2;
      default: exp_port = PORT_NUM_0;
    endcase
  end
  sequence s_select_fall;
    $fell(cfgmem_select_n_out);
  endsequence
  sequence s_first_rise;
    !cfgmem_serial_clock_out [*8] ##[1:4] cfgmem_serial_clock_out;
  endsequence
  property p_refclk;
    1'b1 |=> (refclk_enable & $past(refclk_request_n)) == '0;
  endproperty
  property p_port;
    $rose(debug_out_oe) |-> ##[0:1] upstream_port == exp_port;
  endproperty
  property p_payload;
    $rose(debug_out_oe) |-> ##[0:1] max_payload_code ==
      (large_payload_strap ? MPS_CODE_512 : MPS_CODE_256);
  endproperty
  property p_hold;
    debug_out_oe && $past(debug_out_oe) |-> $stable(upstream_port) &&
      $stable(max_payload_code) && $stable(cfgmem_enabled);
  endproperty
  property p_sysreset;
    !system_reset_n |=> !debug_out_oe && upstream_port == PORT_NUM_0 &&
      max_payload_code == MPS_CODE_256 && !cfgmem_enabled;
  endproperty
  property p_capture;
    $rose(debug_out_oe) |-> $past(system_reset_n);
  endproperty
  property p_bypass;
    !cfgmem_enabled |-> !cfgmem_select_n_oe && !cfgmem_serial_clock_oe;
  endproperty
  property p_first_clock;
    s_select_fall |-> s_first_rise;
  endproperty
  property p_data_steady;
    !cfgmem_select_n_out && cfgmem_serial_clock_out &&
      $past(cfgmem_serial_clock_out) |-> $stable(cfgmem_serial_out);
  endproperty
  property p_open_drain;
    !scl_out && !sda_out;
  endproperty
  property p_read_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  property p_write_ready;
    hsel && hready && htrans[1] && hwrite |=> hreadyout && !hresp;
  endproperty
  a_refclk: assert property (p_refclk)
    else $error("reference clock runs without request");
  a_port: assert property (p_port)
    else $error("upstream port differs from strap");
  a_payload: assert property (p_payload)
    else $error("payload code differs from strap");
  a_hold: assert property (p_hold)
    else $error("captured strap value moved");
  a_sysreset: assert property (p_sysreset)
    else $error("system reset left state behind");
  a_capture: assert property (p_capture)
    else $error("debug pins driven before capture");
  a_bypass: assert property (p_bypass)
    else $error("memory pins driven in bypass");
  a_first_clock: assert property (p_first_clock)
    else $error("memory clock timing after select");
  a_data_steady: assert property (p_data_steady)
    else $error("serial data moved while clock high");
  a_open_drain: assert property (p_open_drain)
    else $error("management line driven high");
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  a_write_ready: assert property (p_write_ready)
    else $error("write not zero wait");
endmodule // strap_port_checker

bind switch_strap_and_eeprom_port strap_port_checker chk_u (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .system_reset_n, .refclk_request_n, .refclk_enable, .upstream_port_strap,
  .large_payload_strap, .upstream_port, .max_payload_code, .cfgmem_enabled,
  .cfgmem_serial_clock_out, .cfgmem_serial_clock_oe, .cfgmem_serial_out,
  .cfgmem_select_n_out, .cfgmem_select_n_oe, .scl_out, .sda_out,
  .debug_out_oe
);

/* testbench/switch_strap_and_eeprom_port_tb.sv */
// Self-checking bench for the strap and config memory port block
`timescale 1ns/1ps
module switch_strap_and_eeprom_port_tb;
  import strap_cfg_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, reply = 32'h0, r, hrdata, got;
  logic [1:0] htrans = 2'h0, upstream_port_strap = 2'h0, upstream_port;
  logic [2:0] hsize = 3'h2, refclk_request_n = 3'h0, max_payload_code;
  logic [2:0] refclk_enable;
  logic system_reset_n = 1'b0, large_payload_strap = 1'b0, sel_strap = 1'b1;
  logic sda_far_low = 1'b0, hreadyout, hresp, cfgmem_enabled, sclk_out;
  logic sclk_oe, cfgmem_serial_out, sel_out, sel_oe, scl_out, scl_oe;
  logic sda_out, sda_oe, debug_out_oe, mem_sdo;
  logic [4:0] debug_out;
  int error_cnt = 0, checks = 0;
  // Pulled-up select and open-drain lines resolved from all drivers
  wire sel_pin = sel_oe ? sel_out : sel_strap;
  wire sclk_pin = sclk_oe ? sclk_out : 1'b0;
  wire scl_pin = !scl_oe;
  wire sda_pin = !(sda_oe || sda_far_low);

  always #2.5 hclk = ~hclk;

  switch_strap_and_eeprom_port dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .system_reset_n,
    .refclk_request_n, .refclk_enable, .upstream_port_strap,
    .large_payload_strap, .upstream_port, .max_payload_code, .cfgmem_enabled,
    .cfgmem_serial_clock_in(sclk_pin), .cfgmem_serial_clock_out(sclk_out),
    .cfgmem_serial_clock_oe(sclk_oe), .cfgmem_serial_out,
    .cfgmem_serial_in(mem_sdo), .cfgmem_select_n_in(sel_pin),
    .cfgmem_select_n_out(sel_out), .cfgmem_select_n_oe(sel_oe),
    .scl_in(scl_pin), .scl_out, .scl_oe, .sda_in(sda_pin), .sda_out, .sda_oe,
    .debug_out, .debug_out_oe
  );
  cfgmem_partner mem_u (.select_n(sel_pin), .sclk(sclk_pin),
    .sdi(cfgmem_serial_out), .reply(reply), .sdo(mem_sdo), .got(got));

  task automatic final_report;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        error_cnt++;
        final_report;
      end
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    q = hrdata;
  endtask
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic boot(input logic [1:0] ups, input logic pl, sel);
    @(posedge hclk);
    system_reset_n <= 1'b0;
    upstream_port_strap <= ups;
    large_payload_strap <= pl;
    sel_strap <= sel;
    repeat (3) @(posedge hclk);
    chk("debug_oe", 32'(debug_out_oe), 32'h0);
    system_reset_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  task automatic t_straps;
    logic [1:0] ep;
    logic [2:0] mc;
    for (int i = 0; i < 8; i++) begin
      ep = (i % 4 == 3) ? PORT_NUM_2 : (i % 4 == 1) ? PORT_NUM_1 : PORT_NUM_0;
      mc = i[2] ? MPS_CODE_512 : MPS_CODE_256;
      boot(2'(i), i[2], 1'b1);
      chk("upstream_port", 32'(upstream_port), 32'(ep));
      chk("payload_code", 32'(max_payload_code), 32'(mc));
      chk("debug_low", 32'(debug_out[3:0]), 32'({ep, 1'b1, i[2]}));
      bus(1'b0, ADDR_STRAP, 32'h0, r);
      chk("strap_reg", r & 32'h1FF,
          {23'h0, 2'h3, mc, i[2], i % 4 == 2, ep});
      upstream_port_strap <= ~2'(i);
      large_payload_strap <= ~i[2];
      repeat (4) @(posedge hclk);
      chk("port_held", 32'(upstream_port), 32'(ep));
    end
  endtask
  task automatic t_refclk;
    logic [2:0] req;
    bus(1'b0, ADDR_REFCLK_OFF, 32'h0, r);
    chk("refclk_off_reset", r, 32'(REFCLK_OFF_RESET));
    for (int k = 0; k < 8; k++) begin
      req = 3'(k) ^ 3'h5;
      bus(1'b1, ADDR_REFCLK_OFF, 32'(k), r);
      refclk_request_n <= req;
      repeat (2) @(posedge hclk);
      chk("refclk_enable", 32'(refclk_enable),
          {29'h0, ~req & ~3'(k)});
    end
  endtask
  task automatic t_mgmt;
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, ADDR_MGMT, 32'(v), r);
      bus(1'b0, ADDR_MGMT, 32'h0, r);
      chk("mgmt_oe", 32'({sda_oe, scl_oe}), 32'(v));
      chk("mgmt_pins", r & 32'h1F, 32'({~2'(v), 2'(v)}));
    end
    sda_far_low <= 1'b1;
    bus(1'b1, ADDR_MGMT, 32'h0, r);
    bus(1'b0, ADDR_MGMT, 32'h0, r);
    chk("sda_far_low", 32'(r[MGMT_SDA_IN_BIT]), 32'h0);
    sda_far_low <= 1'b0;
  endtask
  task automatic t_mem(input logic [4:0] len, input logic hd,
                       input logic [31:0] tx, rep);
    int n;
    reply = rep;
    bus(1'b1, ADDR_MEM_TX, tx, r);
    bus(1'b1, ADDR_MEM_CTRL, 32'h100 | (32'(hd) << 9) | 32'(len), r);
    repeat (3) @(posedge hclk);
    chk("busy_debug", 32'(debug_out[4]), 32'h1);
    n = 0;
    do begin
      bus(1'b0, ADDR_MEM_CTRL, 32'h0, r);
      n++;
    end while (r[CTL_BUSY_BIT] !== 1'b0 && n < 300);
    if (n >= 300) begin
      error_cnt++;
      final_report;
    end
    chk("mem_got", got, tx >> (5'd31 - len));
    bus(1'b0, ADDR_MEM_RX, 32'h0, r);
    chk("mem_rx", r & (32'hFFFFFFFF >> (5'd31 - len)),
        rep >> (5'd31 - len));
    chk("select_idle", 32'({sel_oe, ~hd}), 32'({1'b1, sel_pin}));
  endtask
  task automatic t_bypass;
    boot(2'h0, 1'b0, 1'b0);
    chk("mem_enabled", 32'(cfgmem_enabled), 32'h0);
    bus(1'b1, ADDR_MEM_CTRL, 32'h107, r);
    repeat (30) @(posedge hclk);
    chk("bypass_oe", 32'({sel_oe, sclk_oe}), 32'h0);
    boot(2'h0, 1'b0, 1'b1);
    chk("mem_enabled", 32'(cfgmem_enabled), 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    boot(2'h0, 1'b0, 1'b1);
    bus(1'b0, ADDR_MEM_CTRL, 32'h0, r);
    chk("ctl_reset", r, 32'(CTL_LEN_RESET));
    t_straps;
    t_refclk;
    t_mgmt;
    t_mem(5'd7, 1'b0, 32'hA5000000, 32'h3C000000);
    t_mem(5'd31, 1'b0, 32'h8E2F19C4, 32'h5D7306B1);
    // Hold keeps the select low after the last bit
    t_mem(5'd0, 1'b1, 32'h7FFFFFFF, 32'hFFFFFFFF);
    // Unmapped offsets read zero and swallow writes
    bus(1'b1, 8'h20, 32'hFFFFFFFF, r);
    bus(1'b0, 8'h20, 32'h0, r);
    chk("unmapped", r, 32'h0);
    t_bypass;
    final_report;
  end
endmodule // switch_strap_and_eeprom_port_tb
